/* shared/blrb_pkg.sv */
package blrb_pkg;
    // Serial bus addressing and framing
    localparam logic [6:0] SLAVE_ADDR = 7'h36;
    localparam logic [3:0] BYTE_BITS  = 4'h8;

    // Register offsets
    localparam logic [7:0] OFS_REVISION = 8'h00;
    localparam logic [7:0] OFS_SWRST    = 8'h01;
    localparam logic [7:0] OFS_STRING   = 8'h10;
    localparam logic [1:0][7:0] OFS_ONOFF = {8'h12, 8'h11};
    localparam logic [7:0] OFS_RTRAMP   = 8'h13;
    localparam logic [7:0] OFS_RAMPSEL  = 8'h14;
    localparam logic [7:0] OFS_RSVD     = 8'h15;
    localparam logic [7:0] OFS_MAPCFG   = 8'h16;
    localparam logic [1:0][7:0] OFS_FULLSCALE = {8'h18, 8'h17};
    localparam logic [7:0] OFS_FEEDBACK = 8'h19;
    localparam logic [7:0] OFS_CONVCTL  = 8'h1a;
    localparam logic [7:0] OFS_AUTOTHR  = 8'h1b;
    localparam logic [7:0] OFS_PULSECFG = 8'h1c;
    localparam logic [1:0][7:0] OFS_LVL_LOW  = {8'h22, 8'h20};
    localparam logic [1:0][7:0] OFS_LVL_HIGH = {8'h23, 8'h21};
    localparam logic [7:0] OFS_BANKEN   = 8'h24;
    localparam logic [7:0] OFS_OPEN     = 8'hb0;
    localparam logic [7:0] OFS_SHORT    = 8'hb2;
    localparam logic [7:0] OFS_FAULTEN  = 8'hb4;

    // Reset values
    localparam logic [2:0] RST_STRING   = 3'h6;
    localparam logic [7:0] RST_ONOFF    = 8'h00;
    localparam logic [7:0] RST_RTRAMP   = 8'h00;
    localparam logic [3:0] RST_RAMPSEL  = 4'h0;
    localparam logic [7:0] RSVD_VALUE   = 8'h33;
    localparam logic [7:0] RST_MAPCFG   = 8'h00;
    localparam logic [4:0] RST_FULLSCALE = 5'h13;
    localparam logic [2:0] RST_FEEDBACK = 3'h7;
    localparam logic [4:0] RST_CONVCTL  = 5'h00;
    localparam logic [7:0] RST_AUTOTHR  = 8'hcf;
    localparam logic [3:0] RST_PULSECFG = 4'hc;
    localparam logic [1:0] RST_BANKEN   = 2'h0;

    // Field positions and masks
    localparam int          SWRST_BIT    = 0;
    localparam int          OPEN_EN_BIT  = 0;
    localparam int          SHORT_EN_BIT = 1;
    localparam logic [7:0]  MAPCFG_MASK  = 8'h0d;
    localparam int          LVL_LOW_W    = 3;
    localparam int          LVL_W        = 11;

    // Fastest and slowest ramp steps; the analog side times the ramps
    localparam int RAMP_MIN_US = 2048;
    localparam int RAMP_MAX_MS = 117440;

    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_INDEX, ST_WDATA, ST_RDATA, ST_RACK
    } blrb_state_t;
endpackage : blrb_pkg

/* shared/blrb_line_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface blrb_line_if;
    logic sclRise;
    logic sclFall;
    logic sdaBit;
    logic startEvt;
    logic stopEvt;
    modport sense (output sclRise, sclFall, sdaBit, startEvt, stopEvt);
    modport proto (input  sclRise, sclFall, sdaBit, startEvt, stopEvt);
endinterface : blrb_line_if
`default_nettype wire

/* hdl/blrb_line_sense.sv */
`timescale 1ns/1ns
`default_nettype none
module blrb_line_sense (
    input  wire logic   clk_sys,
    input  wire logic   reset,
    input  wire logic   sclIn,
    input  wire logic   sdaIn,
    blrb_line_if.sense  line
);
    logic sclMeta_q;
    logic sclSync_q;
    logic sclPrev_q;
    logic sdaMeta_q;
    logic sdaSync_q;
    logic sdaPrev_q;

    // Two-stage synchronisers; idle bus reads high
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            sclMeta_q <= 1'b1;
            sclSync_q <= 1'b1;
            sclPrev_q <= 1'b1;
            sdaMeta_q <= 1'b1;
            sdaSync_q <= 1'b1;
            sdaPrev_q <= 1'b1;
        end else begin
            sclMeta_q <= sclIn;
            sclSync_q <= sclMeta_q;
            sclPrev_q <= sclSync_q;
            sdaMeta_q <= sdaIn;
            sdaSync_q <= sdaMeta_q;
            sdaPrev_q <= sdaSync_q;
        end
    end

    wire sclSteadyHigh = sclSync_q & sclPrev_q;

    assign line.sclRise  = sclSync_q & ~sclPrev_q;
    assign line.sclFall  = ~sclSync_q & sclPrev_q;
    assign line.sdaBit   = sdaSync_q;
    // Data moving while the clock is high frames a transfer
    assign line.startEvt = sclSteadyHigh & sdaPrev_q & ~sdaSync_q;
    assign line.stopEvt  = sclSteadyHigh & ~sdaPrev_q & sdaSync_q;
endmodule : blrb_line_sense
`default_nettype wire

/* hdl/blrb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module blrb_top
    import blrb_pkg::*;
#(
    parameter logic [3:0] REV_CODE = 4'h7  // Arbitrary revision value
) (
    input  wire logic                  clk_sys,
    input  wire logic                  reset,
    input  wire logic                  sclIn,
    input  wire logic                  sdaIn,
    output var  logic                  sdaOut,
    output var  logic                  sdaOe,
    input  wire logic [2:0]            openFault,
    input  wire logic [2:0]            shortFault,
    output var  logic [2:0]            stringToBankB,
    output var  logic [7:0]            mappingCfg,
    output var  logic [1:0][4:0]       fullScale,
    output var  logic [2:0]            feedbackEn,
    output var  logic [4:0]            converterCtl,
    output var  logic [7:0]            autoFreqThr,
    output var  logic [3:0]            pulseCfg,
    output var  logic [1:0]            bankEnable,
    output var  logic [1:0][LVL_W-1:0] levelOut,
    output var  logic [1:0]            rampStart,
    output var  logic [1:0][3:0]       rampUpCode,
    output var  logic [1:0][3:0]       rampDownCode,
    output var  logic [1:0]            rampZero
);
    blrb_line_if line ();

    blrb_line_sense u_sense (
        .clk_sys (clk_sys),
        .reset   (reset),
        .sclIn   (sclIn),
        .sdaIn   (sdaIn),
        .line    (line)
    );

    blrb_state_t state_q;
    logic [3:0]  bitCnt_q;
    logic [7:0]  shift_q;
    logic [7:0]  txShift_q;
    logic [7:0]  index_q;
    logic        sdaOe_q;
    logic        sdaOut_q;
    logic        ackHold_q;
    logic        wrPulse_q;
    logic        swReset_q;

    logic [2:0]            stringSel_q;
    logic [1:0][7:0]       onOff_q;
    logic [7:0]            rtRamp_q;
    logic [3:0]            rampSel_q;
    logic [7:0]            mapCfg_q;
    logic [1:0][4:0]       fullScale_q;
    logic [2:0]            feedback_q;
    logic [4:0]            convCtl_q;
    logic [7:0]            autoThr_q;
    logic [3:0]            pulseCfg_q;
    logic [1:0][2:0]       lvlLow_q;
    logic [1:0][7:0]       lvlHigh_q;
    logic [1:0]            bankEn_q;
    logic [2:0]            openFlags_q;
    logic [2:0]            shortFlags_q;
    logic [1:0]            faultEn_q;
    logic [1:0][LVL_W-1:0] level_q;
    logic [1:0]            rampStart_q;
    logic [1:0][3:0]       rampUp_q;
    logic [1:0][3:0]       rampDown_q;
    logic [1:0]            rampZero_q;

    // Serial protocol decode
    wire rxState  = (state_q == ST_ADDR) || (state_q == ST_INDEX) ||
                    (state_q == ST_WDATA);
    wire bitCount = line.sclRise && !ackHold_q &&
                    (rxState || (state_q == ST_RDATA));
    wire byteDone = line.sclFall && !ackHold_q && (bitCnt_q == BYTE_BITS);
    // High-speed master codes never match, so they get no acknowledge
    wire addrHit  = (shift_q[7:1] == SLAVE_ADDR);
    wire takeAddr = byteDone && (state_q == ST_ADDR);
    wire takeIdx  = byteDone && (state_q == ST_INDEX);
    wire takeData = byteDone && (state_q == ST_WDATA);
    wire txDone   = byteDone && (state_q == ST_RDATA);
    wire ackNow   = (takeAddr && addrHit) || takeIdx || takeData;
    wire ackEnd   = line.sclFall && ackHold_q;
    wire rackFall = line.sclFall && (state_q == ST_RACK);
    wire loadTx   = (ackEnd && (state_q == ST_RDATA)) || rackFall;
    wire txNext   = line.sclFall && !ackHold_q && (state_q == ST_RDATA) &&
                    (bitCnt_q != 4'h0) && (bitCnt_q != BYTE_BITS);
    wire nackSeen = line.sclRise && (state_q == ST_RACK) && line.sdaBit;
    logic [7:0] rdData;

    always_ff @(posedge clk_sys) begin
        if (reset || line.stopEvt) begin
            state_q <= ST_IDLE;
        end else if (line.startEvt) begin
            state_q <= ST_ADDR;
        end else if (takeAddr) begin
            state_q <= !addrHit ? ST_IDLE :
                       (shift_q[0] ? ST_RDATA : ST_INDEX);
        end else if (takeIdx) begin
            state_q <= ST_WDATA;
        end else if (txDone) begin
            state_q <= ST_RACK;
        end else if (nackSeen) begin
            state_q <= ST_IDLE;
        end else if (rackFall) begin
            state_q <= ST_RDATA;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset || line.startEvt || ackEnd || rackFall) begin
            bitCnt_q <= 4'h0;
        end else if (bitCount) begin
            bitCnt_q <= bitCnt_q + 4'h1;
        end
    end

    // Receive shifts in most significant bit first
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            shift_q <= 8'h00;
        end else if (bitCount && rxState) begin
            shift_q <= {shift_q[6:0], line.sdaBit};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            txShift_q <= 8'h00;
        end else if (loadTx) begin
            txShift_q <= rdData;
        end else if (txNext) begin
            txShift_q <= {txShift_q[6:0], 1'b0};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset || line.startEvt || line.stopEvt) begin
            ackHold_q <= 1'b0;
        end else if (ackNow) begin
            ackHold_q <= 1'b1;
        end else if (ackEnd) begin
            ackHold_q <= 1'b0;
        end
    end

    // Pull-down enable: acknowledge slot, then read data bits
    always_ff @(posedge clk_sys) begin
        if (reset || line.startEvt || line.stopEvt) begin
            sdaOe_q <= 1'b0;
        end else if (ackNow) begin
            sdaOe_q <= 1'b1;
        end else if (loadTx) begin
            sdaOe_q <= ~rdData[7];
        end else if (ackEnd || txDone) begin
            sdaOe_q <= 1'b0;
        end else if (txNext) begin
            sdaOe_q <= ~txShift_q[6];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            index_q   <= 8'h00;
            wrPulse_q <= 1'b0;
            sdaOut_q  <= 1'b0;
        end else begin
            if (takeIdx) begin
                index_q <= shift_q;
            end
            wrPulse_q <= takeData;
            sdaOut_q  <= 1'b0;
        end
    end

    // Register write decode
    wire wrOn     = wrPulse_q;
    wire wrSwRst  = wrOn && (index_q == OFS_SWRST);
    wire regClr   = reset || swReset_q;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            swReset_q <= 1'b0;
        end else begin
            swReset_q <= wrSwRst && shift_q[SWRST_BIT];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (regClr) begin
            stringSel_q <= RST_STRING;
            rtRamp_q    <= RST_RTRAMP;
            rampSel_q   <= RST_RAMPSEL;
            mapCfg_q    <= RST_MAPCFG;
            feedback_q  <= RST_FEEDBACK;
            convCtl_q   <= RST_CONVCTL;
            autoThr_q   <= RST_AUTOTHR;
            pulseCfg_q  <= RST_PULSECFG;
            bankEn_q    <= RST_BANKEN;
            faultEn_q   <= 2'h0;
        end else if (wrOn) begin
            unique case (index_q)
                OFS_STRING:   stringSel_q <= shift_q[2:0];
                OFS_RTRAMP:   rtRamp_q    <= shift_q;
                OFS_RAMPSEL:  rampSel_q   <= shift_q[3:0];
                OFS_MAPCFG:   mapCfg_q    <= shift_q & MAPCFG_MASK;
                OFS_FEEDBACK: feedback_q  <= shift_q[2:0];
                OFS_CONVCTL:  convCtl_q   <= shift_q[4:0];
                OFS_AUTOTHR:  autoThr_q   <= shift_q;
                OFS_PULSECFG: pulseCfg_q  <= shift_q[3:0];
                OFS_BANKEN:   bankEn_q    <= shift_q[1:0];
                OFS_FAULTEN:  faultEn_q   <= shift_q[1:0];
                default: ;
            endcase
        end
    end

    // Flags follow the detectors only while detection is enabled
    always_ff @(posedge clk_sys) begin
        if (regClr) begin
            openFlags_q  <= 3'h0;
            shortFlags_q <= 3'h0;
        end else begin
            if (faultEn_q[OPEN_EN_BIT]) begin
                openFlags_q <= openFault;
            end
            if (faultEn_q[SHORT_EN_BIT]) begin
                shortFlags_q <= shortFault;
            end
        end
    end

    genvar b;
    generate
        for (b = 0; b < 2; b++) begin : g_bank
            wire       wrLow  = wrOn && (index_q == OFS_LVL_LOW[b]);
            wire       wrHigh = wrOn && (index_q == OFS_LVL_HIGH[b]);
            wire       wrRamp = wrOn && (index_q == OFS_ONOFF[b]);
            wire       wrFs   = wrOn && (index_q == OFS_FULLSCALE[b]);
            wire [1:0] sel    = rampSel_q[2*b +: 2];
            wire [3:0] upSrc  = sel[0] ? onOff_q[b][7:4] : rtRamp_q[7:4];
            wire [3:0] dnSrc  = sel[0] ? onOff_q[b][3:0] : rtRamp_q[3:0];

            always_ff @(posedge clk_sys) begin
                if (regClr) begin
                    onOff_q[b]     <= RST_ONOFF;
                    fullScale_q[b] <= RST_FULLSCALE;
                    lvlLow_q[b]    <= 3'h0;
                    lvlHigh_q[b]   <= 8'h00;
                end else begin
                    if (wrRamp) begin
                        onOff_q[b] <= shift_q;
                    end
                    if (wrFs) begin
                        fullScale_q[b] <= shift_q[4:0];
                    end
                    if (wrLow) begin
                        lvlLow_q[b] <= shift_q[LVL_LOW_W-1:0];
                    end
                    if (wrHigh) begin
                        lvlHigh_q[b] <= shift_q;
                    end
                end
            end

            // The high byte commits both halves and kicks off the ramp
            always_ff @(posedge clk_sys) begin
                if (regClr) begin
                    level_q[b]     <= '0;
                    rampStart_q[b] <= 1'b0;
                end else begin
                    if (wrHigh) begin
                        level_q[b] <= {shift_q, lvlLow_q[b]};
                    end
                    rampStart_q[b] <= wrHigh;
                end
            end

            always_ff @(posedge clk_sys) begin
                if (regClr) begin
                    rampUp_q[b]   <= 4'h0;
                    rampDown_q[b] <= 4'h0;
                    rampZero_q[b] <= 1'b0;
                end else begin
                    rampUp_q[b]   <= upSrc;
                    rampDown_q[b] <= dnSrc;
                    rampZero_q[b] <= sel[1];
                end
            end
        end
    endgenerate

    // Read mux; unused bits and unmapped indexes read zero
    // A process, so the mux follows every register it reads
    always_comb begin : readMux
        logic [7:0] v;
        v = 8'h00;
        unique case (index_q)
            OFS_REVISION:     v = {4'h0, REV_CODE};
            OFS_STRING:       v = {5'h00, stringSel_q};
            OFS_ONOFF[0]:     v = onOff_q[0];
            OFS_ONOFF[1]:     v = onOff_q[1];
            OFS_RTRAMP:       v = rtRamp_q;
            OFS_RAMPSEL:      v = {4'h0, rampSel_q};
            OFS_RSVD:         v = RSVD_VALUE;
            OFS_MAPCFG:       v = mapCfg_q;
            OFS_FULLSCALE[0]: v = {3'h0, fullScale_q[0]};
            OFS_FULLSCALE[1]: v = {3'h0, fullScale_q[1]};
            OFS_FEEDBACK:     v = {5'h00, feedback_q};
            OFS_CONVCTL:      v = {3'h0, convCtl_q};
            OFS_AUTOTHR:      v = autoThr_q;
            OFS_PULSECFG:     v = {4'h0, pulseCfg_q};
            OFS_LVL_LOW[0]:   v = {5'h00, lvlLow_q[0]};
            OFS_LVL_HIGH[0]:  v = lvlHigh_q[0];
            OFS_LVL_LOW[1]:   v = {5'h00, lvlLow_q[1]};
            OFS_LVL_HIGH[1]:  v = lvlHigh_q[1];
            OFS_BANKEN:       v = {6'h00, bankEn_q};
            OFS_OPEN:         v = {5'h00, openFlags_q};
            OFS_SHORT:        v = {5'h00, shortFlags_q};
            OFS_FAULTEN:      v = {6'h00, faultEn_q};
            default:          v = 8'h00;
        endcase
        rdData = v;
    end : readMux

    assign sdaOut        = sdaOut_q;
    assign sdaOe         = sdaOe_q;
    assign stringToBankB = stringSel_q;
    assign mappingCfg    = mapCfg_q;
    assign fullScale     = fullScale_q;
    assign feedbackEn    = feedback_q;
    assign converterCtl  = convCtl_q;
    assign autoFreqThr   = autoThr_q;
    assign pulseCfg      = pulseCfg_q;
    assign bankEnable    = bankEn_q;
    assign levelOut      = level_q;
    assign rampStart     = rampStart_q;
    assign rampUpCode    = rampUp_q;
    assign rampDownCode  = rampDown_q;
    assign rampZero      = rampZero_q;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    a_addr_ack: assert property (
        (takeAddr && addrHit && !line.startEvt && !line.stopEvt)
            |=> sdaOe_q && ackHold_q)
        else $error("matching address not acknowledged");
    a_foreign_addr: assert property (
        (takeAddr && !addrHit && !line.startEvt && !line.stopEvt)
            |=> !sdaOe_q && (state_q == ST_IDLE))
        else $error("foreign address answered");
    a_read_dir: assert property (
        (takeAddr && addrHit && shift_q[0] && !line.startEvt &&
         !line.stopEvt) |=> (state_q == ST_RDATA))
        else $error("read direction not taken");
    a_index_take: assert property (
        (takeIdx && !line.startEvt) |=> (index_q == $past(shift_q)) &&
            (state_q == ST_WDATA))
        else $error("register index not captured");
    a_byte_len: assert property (
        $rose(wrPulse_q) |-> ($past(bitCnt_q, 1) == 4'h8))
        else $error("data byte stored before eight bits");
    a_low_held: assert property (
        (wrOn && (index_q == OFS_LVL_LOW[0]) && !swReset_q)
            |=> $stable(level_q[0]) [*2])
        else $error("low brightness took effect early");
    a_high_apply: assert property (
        (wrOn && (index_q == OFS_LVL_HIGH[1]) && !swReset_q)
            |=> rampStart_q[1] &&
                (level_q[1] == {$past(shift_q), $past(lvlLow_q[1])}))
        else $error("high brightness write not applied");
    a_soft_reset: assert property (
        (wrSwRst && shift_q[SWRST_BIT]) |=> swReset_q ##1
            (!swReset_q && (stringSel_q == RST_STRING) &&
             (bankEn_q == RST_BANKEN)))
        else $error("soft reset did not clear registers");
    a_ramp_zero: assert property (
        (rampSel_q[3] && !swReset_q) |=> rampZero_q[1])
        else $error("immediate ramp not selected for bank B");
    a_fault_hold: assert property (
        (!faultEn_q[OPEN_EN_BIT] && !swReset_q) |=> $stable(openFlags_q))
        else $error("open flags moved while disabled");
    a_bank_enable: assert property (
        (wrOn && (index_q == OFS_BANKEN) && !swReset_q)
            |=> (bankEnable == $past(shift_q[1:0])))
        else $error("bank enable write lost");
endmodule : blrb_top
`default_nettype wire

/* verification/blrb_master.sv */
`timescale 1ns/1ns
`default_nettype none
module blrb_master (
    output var logic scl,
    output var logic sda,
    input  wire logic line
);
    // Clock stands high and data released outside frames
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    task automatic bitx(input logic b, output logic r);
        sda = b;
        #31 scl = 1'b1;
        #31 r = line;
        #32 scl = 1'b0;
        #31;
    endtask : bitx
    task automatic start();
        sda = 1'b1;
        #31 scl = 1'b1;
        #31 sda = 1'b0;
        #31 scl = 1'b0;
    endtask : start
    task automatic stop();
        sda = 1'b0;
        #31 scl = 1'b1;
        #31 sda = 1'b1;
        #31;
    endtask : stop
    // Ninth pulse carries ackIn; 1 releases the line
    task automatic xfer(input logic [7:0] d, input logic ackIn,
                        output logic [7:0] q, output logic ack);
        for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
        bitx(ackIn, ack);
    endtask : xfer
endmodule : blrb_master
`default_nettype wire

/* verification/tb_backlight_i2c_register_bank.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_backlight_i2c_register_bank;
    import blrb_pkg::*;
    logic             clk_sys, reset, scl, sdaM, sdaOe, ackBit;
    logic [2:0]       openFlt, shortFlt, toB, o;
    logic [1:0]       bankEn, rampStart, rampZero;
    logic [1:0][10:0] level;
    logic [1:0][3:0]  upCode, downCode;
    logic [7:0]       q, w, lo, hi, c;
    logic [1:0][7:0]  onoff;
    logic [7:0]       wv [20];
    logic [7:0]       mapOut, thrOut;
    logic [1:0][4:0]  fsOut;
    logic [4:0]       convOut;
    logic [3:0]       pcOut;
    logic [2:0]       fbOut;
    logic             sdaO;
    int               errorCnt, comparisons, seed;
    int               pulses [2];
    wire              line = sdaM & ~sdaOe;
    // Entries are {offset, reset value, writable mask}
    localparam logic [23:0] TBL [20] = '{
        24'h000700, 24'h100607, 24'h1100ff, 24'h1200ff, 24'h1300ff,
        24'h14000f, 24'h153300, 24'h16000d, 24'h17131f, 24'h18131f,
        24'h190707, 24'h1a001f, 24'h1bcfff, 24'h1c0c0f, 24'h200007,
        24'h240003, 24'hb00000, 24'hb20000, 24'hb40003, 24'h300000};
    blrb_top DUT (.clk_sys(clk_sys), .reset(reset), .sclIn(scl),
        .sdaIn(line), .sdaOut(sdaO), .sdaOe(sdaOe), .openFault(openFlt),
        .shortFault(shortFlt), .stringToBankB(toB), .mappingCfg(mapOut),
        .fullScale(fsOut), .feedbackEn(fbOut), .converterCtl(convOut),
        .autoFreqThr(thrOut), .pulseCfg(pcOut), .bankEnable(bankEn),
        .levelOut(level),
        .rampStart(rampStart), .rampUpCode(upCode),
        .rampDownCode(downCode), .rampZero(rampZero));
    blrb_master PEER (.scl(scl), .sda(sdaM), .line(line));
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys)
        for (int b = 0; b < 2; b++) if (rampStart[b] === 1'b1) pulses[b]++;
    function automatic logic [7:0] expVal(input logic [23:0] e,
                                          input logic [7:0] v);
        return (v & e[7:0]) | (e[15:8] & ~e[7:0]);
    endfunction : expVal
    task automatic chkVal(input logic [10:0] got, input logic [10:0] exp);
        comparisons++;
        if (got !== exp) begin
            errorCnt++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chkVal
    task automatic sendOk(input logic [7:0] d);
        PEER.xfer(d, 1'b1, q, ackBit);
        chkVal(ackBit, 1'b0);
    endtask : sendOk
    task automatic sel(input logic [7:0] idx);
        PEER.start();
        sendOk({SLAVE_ADDR, 1'b0});
        sendOk(idx);
    endtask : sel
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        sel(idx);
        sendOk(d);
        PEER.stop();
    endtask : wr
    task automatic rdChk(input logic [7:0] idx, input logic [7:0] exp);
        sel(idx);
        PEER.start();
        sendOk({SLAVE_ADDR, 1'b1});
        PEER.xfer(8'hff, 1'b1, q, ackBit);
        PEER.stop();
        chkVal(q, exp);
    endtask : rdChk
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, errorCnt);
        if (errorCnt == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : summarize
    initial begin
        #900000;
        errorCnt++;
        $display("mismatch at %0t: run limit reached", $time);
        summarize();
    end
    initial begin
        seed = 32'h2062;
        reset = 1'b1;
        openFlt = 3'h0;
        shortFlt = 3'h0;
        repeat (5) @(posedge clk_sys);
        #1 reset = 1'b0;
        repeat (4) @(posedge clk_sys);
        chkVal(toB, 3'h6);
        foreach (TBL[i]) rdChk(TBL[i][23:16], TBL[i][15:8]);
        // Pulse enables are still off when 0x1c is written, and no
        // pulse input reaches this block to hold inactive
        foreach (TBL[i]) begin
            w = $random(seed);
            wv[i] = w;
            wr(TBL[i][23:16], w);
            rdChk(TBL[i][23:16], expVal(TBL[i], w));
        end
        chkVal(mapOut, wv[7] & 8'h0d);
        chkVal(thrOut, wv[12]);
        chkVal(fsOut, {wv[9][4:0], wv[8][4:0]});
        chkVal({fbOut, pcOut}, {wv[10][2:0], wv[13][3:0]});
        chkVal({convOut, toB}, {wv[11][4:0], wv[1][2:0]});
        chkVal(bankEn, wv[15][1:0]);
        $display("test registers done");
        for (int b = 0; b < 2; b++) begin
            lo = $random(seed);
            hi = $random(seed);
            wr(OFS_LVL_LOW[b], lo);
            chkVal(level[b], 11'h0);
            wr(OFS_LVL_HIGH[b], hi);
            chkVal(level[b], {hi, lo[2:0]});
            chkVal(11'(pulses[b]), 11'h1);
            onoff[b] = $random(seed);
            wr(OFS_ONOFF[b], onoff[b]);
        end
        c = $random(seed);
        wr(OFS_RTRAMP, c);
        for (int s = 0; s < 4; s++) begin
            wr(OFS_RAMPSEL, {4'h0, 2'(s), 2'(s)});
            for (int b = 0; b < 2; b++) begin
                chkVal(rampZero[b], s[1]);
                if (s < 2)
                    chkVal({upCode[b], downCode[b]},
                           s[0] ? onoff[b] : c);
            end
        end
        $display("test brightness and ramps done");
        wr(OFS_BANKEN, 8'h00);
        PEER.start();
        PEER.xfer({SLAVE_ADDR ^ 7'h01, 1'b0}, 1'b1, q, ackBit);
        chkVal(ackBit, 1'b1);
        PEER.xfer(OFS_BANKEN, 1'b1, q, ackBit);
        PEER.xfer(8'h03, 1'b1, q, ackBit);
        PEER.start();
        PEER.xfer(8'h08, 1'b1, q, ackBit);
        chkVal(ackBit, 1'b1);
        PEER.stop();
        // Foreign-address write precedes the high-speed code and must not land
        rdChk(OFS_BANKEN, 8'h00);
        wr(OFS_BANKEN, 8'h02);
        chkVal(bankEn, 2'h2);
        wr(OFS_STRING, 8'h01);
        chkVal(toB, 3'h1);
        wr(OFS_SWRST, 8'h01);
        rdChk(OFS_SWRST, 8'h00);
        chkVal(bankEn, RST_BANKEN);
        chkVal(toB, RST_STRING);
        chkVal(level[0], 11'h0);
        chkVal(mapOut, RST_MAPCFG);
        chkVal(thrOut, RST_AUTOTHR);
        chkVal(fsOut, {RST_FULLSCALE, RST_FULLSCALE});
        chkVal({fbOut, pcOut}, {RST_FEEDBACK, RST_PULSECFG});
        chkVal({convOut, sdaO}, {RST_CONVCTL, 1'b0});
        $display("test addressing and soft reset done");
        o = 3'($random(seed));
        @(posedge clk_sys) #1 openFlt = o;
        shortFlt = ~o;
        wr(OFS_FAULTEN, 8'h01);
        rdChk(OFS_OPEN, {5'h0, o});
        // Master acknowledges the first byte, so a second one follows
        PEER.start();
        sendOk({SLAVE_ADDR, 1'b1});
        PEER.xfer(8'hff, 1'b0, q, ackBit);
        chkVal(q, {5'h0, o});
        PEER.xfer(8'hff, 1'b1, q, ackBit);
        PEER.stop();
        chkVal(q, {5'h0, o});
        rdChk(OFS_SHORT, 8'h00);
        wr(OFS_FAULTEN, 8'h02);
        @(posedge clk_sys) #1 openFlt = ~o;
        rdChk(OFS_OPEN, {5'h0, o});
        rdChk(OFS_SHORT, {5'h0, ~o});
        $display("test fault flags done");
        summarize();
    end
endmodule : tb_backlight_i2c_register_bank
`default_nettype wire
